/* File: hw/pace_pkg.sv */
package pace_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_REVISION   = 8'h00;
	localparam logic [7:0] OFS_SOFT_RESET = 8'h04;
	localparam logic [7:0] OFS_PACING     = 8'h0c;
	localparam logic [7:0] OFS_RX_MAX0    = 8'h70;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h90;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h94;
	// field positions
	localparam int RESET_BIT    = 0;
	localparam int PACE_LSB     = 16;
	localparam int PRESCALE_MSB = 11;
	localparam int NUM_CORES    = 3;
	// field masks and reset values
	localparam logic [31:0] PACING_MASK  = 32'h003f_0fff;
	localparam logic [31:0] PACING_RESET = 32'h0000_0000;
	localparam logic [7:0]  MAX_RESET    = 8'h00;
	// window timing
	localparam int WINDOW_NS      = 4000;
	localparam int WINDOWS_PER_MS = 250;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int WINDOW_CYCLES  = WINDOW_NS / CLK_PERIOD_NS;

	// one core's pulse pair
	typedef struct packed {
		logic tx;
		logic rx;
	} pulse_pair_t;
endpackage : pace_pkg

/* File: hw/mac_ctrl_reset_and_pacing.sv */
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module mac_ctrl_reset_and_pacing #(
	parameter logic [31:0] REVISION_VALUE = 32'h0001_0000, // arbitrary value
	parameter int          RAM_WORDS      = 16             // descriptor ram depth
) (
	input  wire logic                      clk,            // 100 mhz reference clock
	input  wire logic                      rst_n,          // sync reset, active low
	input  wire logic                      clk_en,         // freezes all state when low
	input  wire logic [7:0]                avs_address,    // byte address
	input  wire logic                      avs_read,       // read request
	input  wire logic                      avs_write,      // write request
	input  wire logic [31:0]               avs_writedata,  // write data
	input  wire logic [3:0]                avs_byteenable, // byte lanes
	output logic      [31:0]               avs_readdata,   // read data
	output logic                           avs_waitrequest,// stall
	input  wire pace_pkg::pulse_pair_t [2:0] raw_pulse,    // unpaced pulses per core
	output pace_pkg::pulse_pair_t [2:0]    paced_pulse,    // pulses to cores
	output logic                           irq,            // level interrupt
	output logic                           ram_clear_busy  // descriptor ram clearing
);
	localparam int RAM_AW = $clog2(RAM_WORDS);

	logic [31:0]       pacing_ff;
	logic              soft_reset_ff;
	logic [7:0]        max_ff [0:5];
	logic [31:0]       desc_ram [0:RAM_WORDS-1];
	logic [RAM_AW-1:0] clr_idx_ff;
	logic [11:0]       pre_cnt_ff;
	logic [7:0]        win_cnt_ff;
	logic [7:0]        used_ff [0:5];
	logic [5:0]        pend_ff;
	logic [5:0]        stat_ff;
	logic [5:0]        mask_ff;
	logic              ack_ff;
	logic              win_tick;
	logic              ms_tick;
	logic              acc;
	logic              wr_hit;
	logic              rd_hit;
	logic [5:0]        raw_v;
	logic [5:0]        fire;
	logic [31:0]       nxt_rdata;

	// merge byte lanes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// one wait cycle: waitrequest drops the cycle after a request is seen
	assign acc    = (avs_read | avs_write) & ~ack_ff;
	assign wr_hit = avs_write & ack_ff;
	assign rd_hit = avs_read & ack_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else if (clk_en) begin
			ack_ff <= acc;
		end
	end

	// registered stall, high while idle so a fresh request always sees one wait
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else if (clk_en) begin
			avs_waitrequest <= ~acc;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			soft_reset_ff <= 1'b0;
		end else if (clk_en) begin
			soft_reset_ff <= wr_hit && avs_address == pace_pkg::OFS_SOFT_RESET
				&& avs_byteenable[0] && avs_writedata[pace_pkg::RESET_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pacing_ff <= pace_pkg::PACING_RESET;
		end else if (clk_en) begin
			if (soft_reset_ff) begin
				pacing_ff <= pace_pkg::PACING_RESET;
			end else if (wr_hit && avs_address == pace_pkg::OFS_PACING) begin
				pacing_ff <= merge(pacing_ff, avs_writedata, avs_byteenable)
					& pace_pkg::PACING_MASK;
			end
		end
	end

	// per-core max rates, rx then tx for each core
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 6; i++) begin
				max_ff[i] <= pace_pkg::MAX_RESET;
			end
		end else if (clk_en) begin
			for (int i = 0; i < 6; i++) begin
				if (soft_reset_ff) begin
					max_ff[i] <= pace_pkg::MAX_RESET;
				end else if (wr_hit && avs_byteenable[0]
					&& avs_address == pace_pkg::OFS_RX_MAX0 + 8'(i*4)) begin
					max_ff[i] <= avs_writedata[7:0];
				end
			end
		end
	end

	// descriptor ram wipe, one word a cycle; only the clear path writes here
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clr_idx_ff     <= '0;
			ram_clear_busy <= 1'b0;
		end else if (clk_en) begin
			if (soft_reset_ff) begin
				clr_idx_ff     <= '0;
				ram_clear_busy <= 1'b1;
			end else if (ram_clear_busy) begin
				clr_idx_ff <= clr_idx_ff + 1'b1;
				if (clr_idx_ff == RAM_AW'(RAM_WORDS-1)) begin
					ram_clear_busy <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clk_en && ram_clear_busy) begin
			desc_ram[clr_idx_ff] <= 32'h0000_0000;
		end
	end

	// prescale window, then 250 windows make a millisecond
	always_ff @(posedge clk) begin
		if (!rst_n || (clk_en && soft_reset_ff)) begin
			pre_cnt_ff <= 12'h000;
			win_cnt_ff <= 8'h00;
		end else if (clk_en) begin
			if (win_tick) begin
				pre_cnt_ff <= 12'h000;
				win_cnt_ff <= ms_tick ? 8'h00 : win_cnt_ff + 8'h01;
			end else begin
				pre_cnt_ff <= pre_cnt_ff + 12'h001;
			end
		end
	end

	// a zero prescale never opens a window, so paced pulses wait
	assign win_tick = pacing_ff[pace_pkg::PRESCALE_MSB:0] != 12'h000
		&& pre_cnt_ff >= pacing_ff[pace_pkg::PRESCALE_MSB:0] - 12'h001;
	assign ms_tick  = win_tick && win_cnt_ff == 8'(pace_pkg::WINDOWS_PER_MS - 1);

	// pacing decision per channel, index 2k rx and 2k+1 tx
	always_comb begin
		for (int k = 0; k < pace_pkg::NUM_CORES; k++) begin
			raw_v[2*k]   = raw_pulse[k].rx;
			raw_v[2*k+1] = raw_pulse[k].tx;
		end
		for (int i = 0; i < 6; i++) begin
			if (!pacing_ff[pace_pkg::PACE_LSB + i]) begin
				fire[i] = raw_v[i];
			end else begin
				fire[i] = (pend_ff[i] | raw_v[i]) && win_tick && used_ff[i] < max_ff[i];
			end
		end
	end

	// pulse budget per millisecond; a pending pulse is held, not lost, but repeats on that line merge into it
	always_ff @(posedge clk) begin
		if (!rst_n || (clk_en && soft_reset_ff)) begin
			pend_ff <= 6'h00;
			for (int i = 0; i < 6; i++) begin
				used_ff[i] <= 8'h00;
			end
		end else if (clk_en) begin
			for (int i = 0; i < 6; i++) begin
				pend_ff[i] <= pacing_ff[pace_pkg::PACE_LSB + i] & (pend_ff[i] | raw_v[i])
					& ~fire[i];
				if (ms_tick) begin
					// a pulse in the closing window counts against the new budget
					used_ff[i] <= 8'(fire[i] & pacing_ff[pace_pkg::PACE_LSB + i]);
				end else if (fire[i] && pacing_ff[pace_pkg::PACE_LSB + i]) begin
					used_ff[i] <= used_ff[i] + 8'h01;
				end
			end
		end
	end

	// registered pulses to cores
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			paced_pulse <= '0;
		end else if (clk_en) begin
			for (int k = 0; k < pace_pkg::NUM_CORES; k++) begin
				paced_pulse[k].rx <= fire[2*k];
				paced_pulse[k].tx <= fire[2*k+1];
			end
		end
	end

	// sticky status; a read clears only the bits it returned, so a late event survives
	always_ff @(posedge clk) begin
		if (!rst_n || (clk_en && soft_reset_ff)) begin
			stat_ff <= 6'h00;
		end else if (clk_en) begin
			stat_ff <= (rd_hit && avs_address == pace_pkg::OFS_IRQ_STATUS
				? stat_ff & ~avs_readdata[5:0] : stat_ff) | fire;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_ff <= 6'h00;
		end else if (clk_en) begin
			if (soft_reset_ff) begin
				mask_ff <= 6'h00;
			end else if (wr_hit && avs_address == pace_pkg::OFS_IRQ_MASK && avs_byteenable[0]) begin
				mask_ff <= avs_writedata[5:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(stat_ff & mask_ff);
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (avs_address)
			pace_pkg::OFS_REVISION:   nxt_rdata = REVISION_VALUE;
			pace_pkg::OFS_SOFT_RESET: nxt_rdata = {31'h0, soft_reset_ff};
			pace_pkg::OFS_PACING:     nxt_rdata = pacing_ff;
			pace_pkg::OFS_IRQ_STATUS: nxt_rdata = {26'h0, stat_ff};
			pace_pkg::OFS_IRQ_MASK:   nxt_rdata = {26'h0, mask_ff};
			default: begin
				for (int i = 0; i < 6; i++) begin
					if (avs_address == pace_pkg::OFS_RX_MAX0 + 8'(i*4)) begin
						nxt_rdata = {24'h0, max_ff[i]};
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (clk_en && acc) begin
			avs_readdata <= nxt_rdata;
		end
	end

	chk_soft_reset_clears: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && soft_reset_ff |=> pacing_ff == 32'h0 && stat_ff == 6'h0)
		else $error("soft reset did not clear state");
	chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(pacing_ff & ~pace_pkg::PACING_MASK) == 32'h0)
		else $error("reserved pacing bits set");
	chk_unpaced_pass: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !pacing_ff[16] && raw_pulse[0].rx |=> paced_pulse[0].rx)
		else $error("unpaced rx pulse lost");
	chk_rate_budget: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && pacing_ff[17] && used_ff[1] >= max_ff[1] |=> !paced_pulse[0].tx)
		else $error("tx pulse over budget");
	// paced pulse only on a window edge
	chk_window_only: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && pacing_ff[16] && !win_tick |=> !paced_pulse[0].rx)
		else $error("paced pulse outside window");
	chk_revision_read: assert property (@(posedge clk) disable iff (!rst_n)
		rd_hit && avs_address == pace_pkg::OFS_REVISION |-> avs_readdata == REVISION_VALUE)
		else $error("revision word misread");
endmodule : mac_ctrl_reset_and_pacing

/* File: test/pulse_sink.sv */
`timescale 1ns/1ns
// stands in for the interrupt cores: they only latch pulses and never push back
module pulse_sink (
	input  wire logic                        clk,   // reference clock
	input  wire logic                        rst_n, // sync reset, active low
	input  wire pace_pkg::pulse_pair_t [2:0] pulse, // paced pulses in
	output logic [5:0][15:0]                 cnt    // pulses seen, rx at 2k, tx at 2k+1
);
	logic [5:0] flat;
	assign flat = pulse;
	// one counter per line, so a lost or doubled pulse shows
	always_ff @(posedge clk) begin
		for (int k = 0; k < 6; k++) begin
			if (!rst_n) cnt[k] <= 16'h0000;
			else cnt[k] <= cnt[k] + 16'(flat[k]);
		end
	end
endmodule : pulse_sink

/* File: test/tb_mac_ctrl_reset_and_pacing.sv */
`timescale 1ns/1ns
module tb_mac_ctrl_reset_and_pacing;
	localparam logic [31:0] TB_REVISION = 32'h0002_0003; // arbitrary value
	logic                        clk, rst_n, rd, wr, wreq, irq, busy, en;
	logic [7:0]                  addr;
	logic [31:0]                 wdata, rdata, d;
	pace_pkg::pulse_pair_t [2:0] raw, paced;
	logic [5:0][15:0]            cnt;
	int                          err_total, samples_checked, i;

	mac_ctrl_reset_and_pacing #(.REVISION_VALUE(TB_REVISION), .RAM_WORDS(16))
		i_mac_ctrl_reset_and_pacing (
		.clk(clk), .rst_n(rst_n), .clk_en(en), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .raw_pulse(raw), .paced_pulse(paced), .irq(irq),
		.ram_clear_busy(busy));
	pulse_sink i_pulse_sink (.clk(clk), .rst_n(rst_n), .pulse(paced), .cnt(cnt));

	// free-running 100 mhz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task final_report;
		if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask : chk

	// one avalon cycle; request held until waitrequest is seen low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= v;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (wreq === 1'b0) break;
		end
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (i == 20) begin
			err_total++;
			final_report();
		end
	endtask : bus

	task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(n, e, d);
	endtask : rdchk

	// one-cycle raw pulse on a single line
	task fire(input int k);
		@(posedge clk);
		raw <= 6'(1 << k);
		@(posedge clk);
		raw <= '0;
	endtask : fire

	task t_reset_vals;
		rdchk("revision", pace_pkg::OFS_REVISION, TB_REVISION);
		rdchk("pacing", pace_pkg::OFS_PACING, pace_pkg::PACING_RESET);
		rdchk("soft_reset", pace_pkg::OFS_SOFT_RESET, 32'h0000_0000);
		chk("irq_idle", 32'h0, irq);
	endtask : t_reset_vals

	// read-only and unmapped places must shrug off writes
	task t_refused;
		bus(1'b1, pace_pkg::OFS_REVISION, 32'hffff_ffff);
		rdchk("revision_wr", pace_pkg::OFS_REVISION, TB_REVISION);
		bus(1'b1, 8'h40, 32'h0000_1234);
		rdchk("unmapped", 8'h40, 32'h0000_0000);
		bus(1'b1, pace_pkg::OFS_PACING, 32'hffff_ffff);
		rdchk("pacing_mask", pace_pkg::OFS_PACING, pace_pkg::PACING_MASK);
	endtask : t_refused

	// pacing off: each line passes one cycle later, alone
	task t_unpaced;
		bus(1'b1, pace_pkg::OFS_PACING, 32'h0000_0000);
		for (int k = 0; k < 6; k++) begin
			fire(k);
			@(posedge clk);
			chk("paced_line", 32'(1 << k), 32'(paced));
		end
	endtask : t_unpaced

	task t_irq;
		chk("irq_masked", 32'h0, irq);
		bus(1'b1, pace_pkg::OFS_IRQ_MASK, 32'h0000_003f);
		repeat (2) @(posedge clk);
		chk("irq_unmasked", 32'h1, irq);
		rdchk("status", pace_pkg::OFS_IRQ_STATUS, 32'h0000_003f);
		repeat (2) @(posedge clk);
		chk("irq_cleared", 32'h0, irq);
		rdchk("status_clr", pace_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
	endtask : t_irq

	// rx0 paced at one pulse per 250 windows (1000 clocks), window of a few clocks
	task t_paced;
		logic [15:0] base;
		base = cnt[0];
		bus(1'b1, pace_pkg::OFS_RX_MAX0, 32'h0000_0001);
		bus(1'b1, pace_pkg::OFS_PACING, 32'h0001_0004);
		repeat (3) fire(0);
		repeat (200) @(posedge clk);
		chk("paced_one", 32'(base + 16'h1), 32'(cnt[0]));
		fire(0);
		repeat (1500) @(posedge clk);
		chk("paced_two", 32'(base + 16'h2), 32'(cnt[0]));
	endtask : t_paced

	task t_soft;
		bus(1'b1, pace_pkg::OFS_PACING, 32'h0003_0123);
		bus(1'b1, pace_pkg::OFS_SOFT_RESET, 32'h0000_0000);
		rdchk("no_reset", pace_pkg::OFS_PACING, 32'h0003_0123);
		bus(1'b1, pace_pkg::OFS_SOFT_RESET, 32'h0000_0001);
		for (i = 0; i < 5 && busy !== 1'b1; i++) @(posedge clk);
		chk("wipe_start", 32'h1, busy);
		for (i = 0; i < 24 && busy !== 1'b0; i++) @(posedge clk);
		chk("wipe_end", 32'h0, busy);
		rdchk("pacing_clr", pace_pkg::OFS_PACING, 32'h0000_0000);
		rdchk("max_clr", pace_pkg::OFS_RX_MAX0, 32'h0000_0000);
		rdchk("status_clr", pace_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
		rdchk("mask_clr", pace_pkg::OFS_IRQ_MASK, 32'h0000_0000);
	endtask : t_soft

	// clock enable low: a raw pulse is neither passed nor held for later
	task t_freeze;
		logic [15:0] base;
		base = cnt[0];
		@(posedge clk);
		en <= 1'b0;
		fire(0);
		repeat (3) @(posedge clk);
		en <= 1'b1;
		repeat (3) @(posedge clk);
		chk("frozen_line", 32'(base), 32'(cnt[0]));
	endtask : t_freeze

	// reset for three cycles, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		en = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		raw = '0;
		err_total = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_vals();
		t_refused();
		t_unpaced();
		t_irq();
		t_paced();
		t_soft();
		t_freeze();
		final_report();
	end
endmodule : tb_mac_ctrl_reset_and_pacing
